// ===== rtl/phy_stats_defs.svh
// Offsets, field positions, reset values and timing figures of the statistics register group
`ifndef PHY_STATS_DEFS_SVH
`define PHY_STATS_DEFS_SVH

// Register offsets on the management port
`define REG_PHY_ADDRESS      5'h12
`define REG_FALSE_CARRIER    5'h13
`define REG_DISCONNECT       5'h14
`define REG_ERROR_FRAME      5'h15
`define REG_SYMBOL_ERROR     5'h16
`define REG_EARLY_FRAME_END  5'h17
`define REG_FRAME_END_ERROR  5'h18
`define REG_JABBER           5'h19
`define REG_EQUALIZER        5'h1a
`define REG_LED_SELECT       5'h1b
`define REG_CROSSOVER        5'h1c

// Fixed address value, reset values and the counter full value
`define PHY_ADDRESS_VALUE    16'h0001
`define EQUALIZER_RESET      16'h0000
`define LED_SELECT_RESET     3'h0
`define COUNTER_FULL         16'hffff

// Crossover control field positions
`define XO_AUTO_BIT          7
`define XO_MANUAL_BIT        6
`define XO_STATUS_BIT        5
`define XO_DONE_BIT          4
`define XO_TIMER_MSB         3

// Counter slots and symbol run length
`define NUM_COUNTERS         7
`define SYMBOL_RUN_LAST      3'h5

// Slot time figures
`define CLK_PERIOD_NS        8
`define SLOT_MIN_MS          80
`define SLOT_MAX_MS          105
`define NS_PER_MS            1000000
`define SLOT_CODE_STEPS      15

`endif

// ===== rtl/phy_stats_pkg.sv
// Types shared by the statistics register group
package phy_stats_pkg;

   // Crossover resolution states
   typedef enum logic [1:0] {
      xo_manual,
      xo_hunt,
      xo_locked
   } xover_state_e;

   typedef logic [15:0] reg_word_t;

endpackage : phy_stats_pkg

// ===== rtl/sat_rc_counter.sv
// Saturating event counter that clears on a management read
`timescale 1ns/1ps
`include "phy_stats_defs.svh"

module sat_rc_counter
   import phy_stats_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      reset,
   input  wire logic      inc,
   input  wire logic      clr,
   output reg_word_t      count
);

   reg_word_t count_r;
   reg_word_t count_nxt;

   // Read clears, but an event in the same cycle is kept as one count
   always_comb begin
      count_nxt = count_r;
      if (clr) begin
         count_nxt = inc ? 16'h0001 : 16'h0000;
      end else if (inc && count_r != `COUNTER_FULL) begin
         count_nxt = count_r + 16'h0001;
      end
   end

   // Counter state, cleared at reset
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count_r <= 16'h0000;
      end else begin
         count_r <= count_nxt;
      end
   end

   assign count = count_r;

endmodule : sat_rc_counter

// ===== rtl/phy_stats_regs.sv
// Statistics, LED select and crossover control registers of the PHY management space
`timescale 1ns/1ps
`include "phy_stats_defs.svh"

module phy_stats_regs
   import phy_stats_pkg::*;
#(
   parameter int SLOT_MIN_CYCLES = `SLOT_MIN_MS * (`NS_PER_MS / `CLK_PERIOD_NS),
   parameter int SLOT_MAX_CYCLES = `SLOT_MAX_MS * (`NS_PER_MS / `CLK_PERIOD_NS)
)
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [4:0]  mgmt_addr,
   input  wire logic        mgmt_rd,
   input  wire logic        mgmt_wr,
   input  wire logic [15:0] mgmt_wdata,
   output reg_word_t        mgmt_rdata,
   output logic             mgmt_rvalid,
   input  wire logic        false_carrier_evt,
   input  wire logic        disconnect_evt,
   input  wire logic        rx_frame_active,
   input  wire logic        rx_symbol_valid,
   input  wire logic        rx_symbol_err,
   input  wire logic        early_end_evt,
   input  wire logic        frame_end_err_evt,
   input  wire logic        jabber_evt,
   input  wire logic        link_up,
   input  wire logic        speed_100,
   input  wire logic        activity,
   input  wire logic        collision,
   output logic             activity_led_n,
   output logic             link_led_n,
   output logic             mdix_select
);

   // True for the seven counter offsets
   function automatic logic is_counter(input logic [4:0] a);
      return (a >= `REG_FALSE_CARRIER) && (a <= `REG_JABBER);
   endfunction : is_counter

   // Counter slot index from an offset
   function automatic logic [2:0] counter_slot(input logic [4:0] a);
      logic [4:0] d;
      d = a - `REG_FALSE_CARRIER;
      return d[2:0];
   endfunction : counter_slot

   logic [`NUM_COUNTERS-1:0] cnt_inc;
   logic [`NUM_COUNTERS-1:0] cnt_clr;
   reg_word_t                cnt_val [`NUM_COUNTERS];

   logic [2:0]   sym_run_r;
   logic [2:0]   sym_run_nxt;
   logic         frame_err_r;
   logic         frame_err_nxt;
   logic         sym_inc;
   logic         err_frame_inc;
   logic         bad_symbol;
   logic         err_now;

   // Frame error tracking and symbol run counting
   always_comb begin
      bad_symbol    = rx_frame_active && rx_symbol_valid && rx_symbol_err;
      err_now       = bad_symbol || (rx_frame_active && early_end_evt);
      sym_inc       = 1'b0;
      sym_run_nxt   = sym_run_r;
      err_frame_inc = err_now && !frame_err_r;
      frame_err_nxt = rx_frame_active && (frame_err_r || err_now);
      if (!rx_frame_active) begin
         sym_run_nxt = 3'h0;
      end else if (rx_symbol_valid) begin
         if (!rx_symbol_err) begin
            sym_run_nxt = 3'h0;
         end else if (sym_run_r == `SYMBOL_RUN_LAST) begin
            sym_run_nxt = 3'h0;
            sym_inc     = 1'b1;
         end else begin
            sym_run_nxt = sym_run_r + 3'h1;
         end
      end
   end

   // Frame tracking state
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sym_run_r   <= 3'h0;
         frame_err_r <= 1'b0;
      end else begin
         sym_run_r   <= sym_run_nxt;
         frame_err_r <= frame_err_nxt;
      end
   end

   assign cnt_inc = {jabber_evt, frame_end_err_evt, early_end_evt, sym_inc,
                     err_frame_inc, disconnect_evt, false_carrier_evt};

   generate
      for (genvar i = 0; i < `NUM_COUNTERS; i++) begin : g_cnt
         assign cnt_clr[i] = mgmt_rd && is_counter(mgmt_addr)
                             && (counter_slot(mgmt_addr) == 3'(i));
         sat_rc_counter u_cnt (
            .clk   (clk),
            .reset (reset),
            .inc   (cnt_inc[i]),
            .clr   (cnt_clr[i]),
            .count (cnt_val[i])
         );
      end
   endgenerate

   reg_word_t    eq_r;
   reg_word_t    eq_nxt;
   logic [2:0]   led_sel_r;
   logic [2:0]   led_sel_nxt;
   logic [7:0]   xo_hi_r;
   logic [7:0]   xo_hi_nxt;
   logic         auto_en_r;
   logic         auto_en_nxt;
   logic         manual_x_r;
   logic         manual_x_nxt;
   logic [3:0]   slot_code_r;
   logic [3:0]   slot_code_nxt;

   // Writable fields
   always_comb begin
      eq_nxt        = eq_r;
      led_sel_nxt   = led_sel_r;
      xo_hi_nxt     = xo_hi_r;
      auto_en_nxt   = auto_en_r;
      manual_x_nxt  = manual_x_r;
      slot_code_nxt = slot_code_r;
      if (mgmt_wr) begin
         unique case (mgmt_addr)
            `REG_EQUALIZER:  eq_nxt = mgmt_wdata;
            `REG_LED_SELECT: led_sel_nxt = mgmt_wdata[2:0];
            `REG_CROSSOVER: begin
               xo_hi_nxt     = mgmt_wdata[15:8];
               auto_en_nxt   = mgmt_wdata[`XO_AUTO_BIT];
               manual_x_nxt  = mgmt_wdata[`XO_MANUAL_BIT];
               slot_code_nxt = mgmt_wdata[`XO_TIMER_MSB:0];
            end
            default: eq_nxt = eq_r;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         eq_r        <= `EQUALIZER_RESET;
         led_sel_r   <= `LED_SELECT_RESET;
         xo_hi_r     <= 8'h00;
         auto_en_r   <= 1'b0;
         manual_x_r  <= 1'b0;
         slot_code_r <= 4'h0;
      end else begin
         eq_r        <= eq_nxt;
         led_sel_r   <= led_sel_nxt;
         xo_hi_r     <= xo_hi_nxt;
         auto_en_r   <= auto_en_nxt;
         manual_x_r  <= manual_x_nxt;
         slot_code_r <= slot_code_nxt;
      end
   end

   xover_state_e xo_state_r;
   xover_state_e xo_state_nxt;
   logic         mdix_r;
   logic         mdix_nxt;
   logic [23:0]  slot_cnt_r;
   logic [23:0]  slot_cnt_nxt;
   logic [31:0]  slot_limit;
   logic         xo_done;

   // slot length scales linearly with the timer code
   assign slot_limit = 32'(SLOT_MIN_CYCLES)
                     + (32'(SLOT_MAX_CYCLES - SLOT_MIN_CYCLES) * {28'h0, slot_code_r})
                       / 32'(`SLOT_CODE_STEPS);
   assign xo_done = (xo_state_r != xo_hunt);

   // Crossover resolution: toggle pairs each slot until link comes up
   always_comb begin
      xo_state_nxt = xo_state_r;
      mdix_nxt     = mdix_r;
      slot_cnt_nxt = slot_cnt_r;
      unique case (xo_state_r)
         xo_manual: begin
            mdix_nxt     = manual_x_r;
            slot_cnt_nxt = 24'h0;
            if (auto_en_r) begin
               xo_state_nxt = xo_hunt;
            end
         end
         xo_hunt: begin
            if (!auto_en_r) begin
               xo_state_nxt = xo_manual;
            end else if (link_up) begin
               xo_state_nxt = xo_locked;
            end else if ({8'h0, slot_cnt_r} >= slot_limit - 32'h1) begin
               mdix_nxt     = !mdix_r;
               slot_cnt_nxt = 24'h0;
            end else begin
               slot_cnt_nxt = slot_cnt_r + 24'h1;
            end
         end
         xo_locked: begin
            slot_cnt_nxt = 24'h0;
            if (!auto_en_r) begin
               xo_state_nxt = xo_manual;
            end else if (!link_up) begin
               xo_state_nxt = xo_hunt;
            end
         end
      endcase
   end

   // Crossover state
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         xo_state_r <= xo_manual;
         mdix_r     <= 1'b0;
         slot_cnt_r <= 24'h0;
      end else begin
         xo_state_r <= xo_state_nxt;
         mdix_r     <= mdix_nxt;
         slot_cnt_r <= slot_cnt_nxt;
      end
   end

   assign mdix_select = mdix_r;

   reg_word_t rdata_r;
   reg_word_t rdata_nxt;
   logic      rvalid_r;
   logic      act_led_n_r;
   logic      act_led_n_nxt;
   logic      link_led_n_r;
   logic      link_led_n_nxt;

   // Read mux and LED selection
   always_comb begin
      rdata_nxt = 16'h0000;
      if (is_counter(mgmt_addr)) begin
         rdata_nxt = cnt_val[counter_slot(mgmt_addr)];
      end else begin
         unique case (mgmt_addr)
            `REG_PHY_ADDRESS: rdata_nxt = `PHY_ADDRESS_VALUE;
            `REG_EQUALIZER:   rdata_nxt = eq_r;
            `REG_LED_SELECT:  rdata_nxt = {13'h0, led_sel_r};
            `REG_CROSSOVER:   rdata_nxt = {xo_hi_r, auto_en_r, manual_x_r,
                                           mdix_r, xo_done, slot_code_r};
            default:          rdata_nxt = 16'h0000;
         endcase
      end
      unique case (led_sel_r)
         3'h0, 3'h3: act_led_n_nxt = !activity;
         3'h1, 3'h2: act_led_n_nxt = !speed_100;
         3'h4, 3'h5: act_led_n_nxt = 1'b1;
         3'h6, 3'h7: act_led_n_nxt = 1'b0;
      endcase
      unique case (led_sel_r)
         3'h0, 3'h2: link_led_n_nxt = !link_up;
         3'h1, 3'h3: link_led_n_nxt = !collision;
         3'h4, 3'h6: link_led_n_nxt = 1'b1;
         3'h5, 3'h7: link_led_n_nxt = 1'b0;
      endcase
   end

   // Read data and LED outputs
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata_r      <= 16'h0000;
         rvalid_r     <= 1'b0;
         act_led_n_r  <= 1'b1;
         link_led_n_r <= 1'b1;
      end else begin
         rdata_r      <= mgmt_rd ? rdata_nxt : rdata_r;
         rvalid_r     <= mgmt_rd;
         act_led_n_r  <= act_led_n_nxt;
         link_led_n_r <= link_led_n_nxt;
      end
   end

   assign mgmt_rdata     = rdata_r;
   assign mgmt_rvalid    = rvalid_r;
   assign activity_led_n = act_led_n_r;
   assign link_led_n     = link_led_n_r;

   // Checks on the register behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_six_bad;
      (bad_symbol && sym_run_r == 3'h0) ##1 bad_symbol [*5];
   endsequence

   property p_phy_addr;
      mgmt_rd && mgmt_addr == `REG_PHY_ADDRESS |=> mgmt_rdata == 16'h0001;
   endproperty
   a_phy_addr: assert property (p_phy_addr) else $error("address read wrong");

   property p_read_clears;
      mgmt_rd && mgmt_addr == `REG_FALSE_CARRIER && !false_carrier_evt
         |=> cnt_val[0] == 16'h0000 && mgmt_rdata == $past(cnt_val[0]);
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("read did not clear");

   property p_disc_inc;
      disconnect_evt && !cnt_clr[1] && cnt_val[1] != 16'hffff
         |=> cnt_val[1] == $past(cnt_val[1]) + 16'h0001;
   endproperty
   a_disc_inc: assert property (p_disc_inc) else $error("disconnect not counted");

   property p_err_frame_once;
      err_frame_inc ##1 rx_frame_active |-> !err_frame_inc;
   endproperty
   a_err_frame_once: assert property (p_err_frame_once) else $error("frame counted twice");

   property p_six_symbols;
      s_six_bad |-> sym_inc ##1 sym_run_r == 3'h0;
   endproperty
   a_six_symbols: assert property (p_six_symbols) else $error("six bad symbols missed");

   property p_jabber_hold;
      cnt_val[6] == 16'hffff && !cnt_clr[6] |=> cnt_val[6] == 16'hffff;
   endproperty
   a_jabber_hold: assert property (p_jabber_hold) else $error("counter wrapped");

   property p_led_off;
      led_sel_r == 3'h4 ##1 led_sel_r == 3'h4 |-> activity_led_n && link_led_n;
   endproperty
   a_led_off: assert property (p_led_off) else $error("LEDs not off");

   property p_led_on7;
      led_sel_r == 3'h7 ##1 led_sel_r == 3'h7 |-> !activity_led_n && !link_led_n;
   endproperty
   a_led_on7: assert property (p_led_on7) else $error("LEDs not on");

   property p_auto_write;
      mgmt_wr && mgmt_addr == `REG_CROSSOVER |=> auto_en_r == $past(mgmt_wdata[7]);
   endproperty
   a_auto_write: assert property (p_auto_write) else $error("auto enable not written");

   property p_manual;
      xo_state_r == xo_manual && !auto_en_r |=> mdix_r == $past(manual_x_r);
   endproperty
   a_manual: assert property (p_manual) else $error("manual pair wrong");

   property p_status;
      mgmt_rd && mgmt_addr == `REG_CROSSOVER
         |=> mgmt_rdata[5] == $past(mdix_r) && mgmt_rdata[4] == $past(xo_done);
   endproperty
   a_status: assert property (p_status) else $error("crossover status wrong");

   property p_slot_bound;
      xo_state_r == xo_hunt |-> {8'h0, slot_cnt_r} < slot_limit;
   endproperty
   a_slot_bound: assert property (p_slot_bound) else $error("slot overran");

endmodule : phy_stats_regs

// ===== verif/mac_host.sv
// Management host model that issues register reads and writes
`timescale 1ns/1ps
`include "phy_stats_defs.svh"

module mac_host (
   input  wire logic        clk,
   output logic [4:0]       mgmt_addr,
   output logic             mgmt_rd,
   output logic             mgmt_wr,
   output logic [15:0]      mgmt_wdata
);

   // Idle bus at time zero
   initial begin
      mgmt_addr  = 5'h00;
      mgmt_rd    = 1'b0;
      mgmt_wr    = 1'b0;
      mgmt_wdata = 16'h0000;
   end

   // One-cycle read strobe; address moves away once taken
   task rd(input logic [4:0] a);
      @(posedge clk);
      mgmt_addr <= a;
      mgmt_rd   <= 1'b1;
      @(posedge clk);
      mgmt_rd   <= 1'b0;
      mgmt_addr <= ~a;
   endtask : rd

   // One-cycle write strobe; data inverted after the taking edge
   task wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      mgmt_addr  <= a;
      mgmt_wdata <= (a == `REG_CROSSOVER) ? (d & 16'h00ff) : d;
      mgmt_wr    <= 1'b1;
      @(posedge clk);
      mgmt_wr    <= 1'b0;
      mgmt_wdata <= ~d;
   endtask : wr

endmodule : mac_host

// ===== verif/phy_stats_regs_tb.sv
// Self-checking bench for the statistics, LED and crossover registers
`timescale 1ns/1ps
`include "phy_stats_defs.svh"

module phy_stats_regs_tb
   import phy_stats_pkg::*;
;
   localparam int SMIN = 20;
   localparam int SMAX = 35;

   logic        clk;
   logic        reset;
   logic [4:0]  addr;
   logic        rd;
   logic        wr;
   logic [15:0] wdata;
   reg_word_t   rdata;
   logic        rvalid;
   logic [4:0]  evt;
   logic        frame;
   logic        sv;
   logic        se;
   logic        link_up;
   logic        speed_100;
   logic        activity;
   logic        collision;
   logic        act_n;
   logic        link_n;
   logic        mdix;
   reg_word_t   q[$];
   int          miscompares = 0;
   int          check_count = 0;
   int          cycles = 0;
   logic [4:0]  cnt_addr [5] = '{`REG_FALSE_CARRIER, `REG_DISCONNECT, `REG_EARLY_FRAME_END,
                                  `REG_FRAME_END_ERROR, `REG_JABBER};

   mac_host host (.clk(clk), .mgmt_addr(addr), .mgmt_rd(rd), .mgmt_wr(wr), .mgmt_wdata(wdata));

   phy_stats_regs #(.SLOT_MIN_CYCLES(SMIN), .SLOT_MAX_CYCLES(SMAX)) DUT (
      .clk(clk), .reset(reset), .mgmt_addr(addr), .mgmt_rd(rd), .mgmt_wr(wr),
      .mgmt_wdata(wdata), .mgmt_rdata(rdata), .mgmt_rvalid(rvalid),
      .false_carrier_evt(evt[0]), .disconnect_evt(evt[1]), .rx_frame_active(frame),
      .rx_symbol_valid(sv), .rx_symbol_err(se), .early_end_evt(evt[2]),
      .frame_end_err_evt(evt[3]), .jabber_evt(evt[4]), .link_up(link_up),
      .speed_100(speed_100), .activity(activity), .collision(collision),
      .activity_led_n(act_n), .link_led_n(link_n), .mdix_select(mdix));

   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task check(input string name, input reg_word_t exp, input reg_word_t seen);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task end_sim;
      if (miscompares == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_sim

   // Note the expected word, then read it
   task rd_chk(input logic [4:0] a, input reg_word_t e);
      q.push_back(e);
      host.rd(a);
   endtask : rd_chk

   task pulse(input int idx, input int n);
      repeat (n) begin
         evt <= 5'h01 << idx;
         @(posedge clk);
      end
      evt <= 5'h00;
   endtask : pulse

   // Symbols stay driven after the last one; the caller idles the lines
   task sym(input logic bad, input int n);
      repeat (n) begin
         {sv, se} <= {1'b1, bad};
         @(posedge clk);
      end
   endtask : sym

   // Cycles until the pair selection changes, capped at 60
   task wait_toggle(output int n);
      logic last;
      last = mdix;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (mdix === last && n < 60);
   endtask : wait_toggle

   function automatic reg_word_t rst_val(input logic [4:0] a);
      return (a == `REG_PHY_ADDRESS) ? 16'h0001 : (a == `REG_CROSSOVER) ? 16'h0010 : 16'h0000;
   endfunction : rst_val

   // Read answers are compared in order against the notes
   always @(posedge clk) begin
      if (rvalid === 1'b1) begin
         if (q.size() == 0)
            check("read without request", 16'h0000, 16'h0001);
         else
            check("read data", q.pop_front(), rdata);
      end
   end

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         miscompares++;
         end_sim();
      end
   end

   // Main sequence
   initial begin
      reg_word_t  r;
      int         n;
      logic [2:0] s;
      logic [3:0] code;
      logic       a;
      logic       l;
      reset = 1'b1;
      evt = 5'h00;
      frame = 1'b0;
      sv = 1'b0;
      se = 1'b0;
      {link_up, speed_100, activity, collision} = 4'h0;
      void'($urandom(91));
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      for (int i = 16; i < 31; i++) rd_chk(5'(i), rst_val(5'(i)));
      // Read-only and unmapped places ignore writes; the equalizer takes its write
      r = 16'($urandom);
      for (int i = 18; i < 27; i++) host.wr(5'(i), r);
      host.wr(5'h1e, r);
      for (int i = 18; i < 26; i++) rd_chk(5'(i), rst_val(5'(i)));
      rd_chk(5'h1e, 16'h0000);
      rd_chk(`REG_EQUALIZER, r);
      // Each of the five pulsed counters: random burst, read, read again
      for (int i = 0; i < 5; i++) begin
         n = 1 + $urandom % 40;
         pulse(i, n);
         rd_chk(cnt_addr[i], 16'(n));
         rd_chk(cnt_addr[i], 16'h0000);
      end
      pulse(4, 65540);
      rd_chk(`REG_JABBER, 16'hffff);
      rd_chk(`REG_JABBER, 16'h0000);
      // Bad symbol runs broken by good ones in a frame, bad symbols outside a frame, then a second frame
      frame <= 1'b1;
      @(posedge clk);
      sym(1'b1, 13);
      sym(1'b0, 1);
      sym(1'b1, 5);
      sym(1'b0, 1);
      {sv, se} <= 2'b00;
      pulse(2, 1);
      frame <= 1'b0;
      @(posedge clk);
      sym(1'b1, 6);
      {sv, se} <= 2'b00;
      frame <= 1'b1;
      @(posedge clk);
      pulse(2, 1);
      frame <= 1'b0;
      @(posedge clk);
      rd_chk(`REG_SYMBOL_ERROR, 16'h0002);
      rd_chk(`REG_ERROR_FRAME, 16'h0002);
      rd_chk(`REG_EARLY_FRAME_END, 16'h0002);
      // LED selector, every code
      for (int i = 0; i < 8; i++) begin
         s = 3'(i);
         {link_up, speed_100, activity, collision} <= 4'($urandom);
         host.wr(`REG_LED_SELECT, {13'($urandom), s});
         repeat (2) @(posedge clk);
         #1;
         a = s[2] ? s[1] : ((s[1] ^ s[0]) ? speed_100 : activity);
         l = s[2] ? s[0] : (s[0] ? collision : link_up);
         check("activity_led_n", 16'(!a), 16'(act_n));
         check("link_led_n", 16'(!l), 16'(link_n));
         rd_chk(`REG_LED_SELECT, {13'h0000, s});
      end
      // Manual pair selection
      @(posedge clk);
      link_up <= 1'b0;
      code = 4'($urandom);
      host.wr(`REG_CROSSOVER, {12'h004, code});
      repeat (3) @(posedge clk);
      #1;
      check("mdix_select", 16'h0001, 16'(mdix));
      rd_chk(`REG_CROSSOVER, {12'h007, code});
      host.wr(`REG_CROSSOVER, {12'h000, code});
      repeat (3) @(posedge clk);
      #1;
      check("mdix_select", 16'h0000, 16'(mdix));
      rd_chk(`REG_CROSSOVER, {12'h001, code});
      // Automatic hunt at both timer ends and one random code
      for (int k = 0; k < 3; k++) begin
         code = (k == 0) ? 4'h0 : (k == 1) ? 4'hf : 4'($urandom);
         host.wr(`REG_CROSSOVER, {12'h008, code});
         rd_chk(`REG_CROSSOVER, {12'h008, code});
         wait_toggle(n);
         wait_toggle(n);
         check("slot", 16'(SMIN + (SMAX - SMIN) * code / 15), 16'(n));
         wait_toggle(n);
         check("slot", 16'(SMIN + (SMAX - SMIN) * code / 15), 16'(n));
         repeat ((SMIN + code) / 2) @(posedge clk);
         link_up <= 1'b1;
         repeat (3) @(posedge clk);
         rd_chk(`REG_CROSSOVER, {12'h00b, code});
         wait_toggle(n);
         check("locked", 16'd60, 16'(n));
         @(posedge clk);
         link_up <= 1'b0;
         host.wr(`REG_CROSSOVER, 16'h0000);
         repeat (3) @(posedge clk);
      end
      check("read queue", 16'h0000, 16'(q.size()));
      end_sim();
   end

endmodule : phy_stats_regs_tb
